// file: src/xskip_map.svh
/*
  opcode fields, encodings and reset values for the skip/xor/extended decoder.
  assumes 16-bit instruction words and an 8-bit data path.
*/
`ifndef XSKIP_MAP_SVH
`define XSKIP_MAP_SVH
`define OP_TSTSKIP_HI   7'h33
`define OP_XORLIT_HI    8'h0A
`define OP_XORFILE_HI   6'h06
`define OP_EXT_HI       6'h3A
`define OP_ADDPTR_HI    8'hE8
`define OP_SUBPTR_HI    8'hE9
`define OP_TWOWORD_HI   4'hF
`define OP_CALL_VIA_WORK 16'h0014
`define OP_MOVE_PAIR_HI 4'hC
`define OP_CALL_PAIR_HI 7'h76
`define OP_EXT_PAIR_HI  8'hEB
`define ADDR_RESET      12'h000
`define PAGE_LOW        4'h0
`define PAGE_HIGH       4'hF
`define PTR2_SEL        2'h3
`define PTR2_INDEX      2'h2
`define IDX_LIMIT       8'h5F
`define ACCESS_SPLIT    8'h60
`define WORK_RESET      8'h00
`define PTR_RESET       12'h000
`define STD_COUNT       75
`define EXT_COUNT       8
`define BIT_ACCESS      8
`define BIT_DEST        9
`endif

// file: src/xskip_pkg.sv
/*
  types used by the decoder for its execute state.
  assumes nothing beyond the map header.
*/
package xskip_pkg;
  typedef enum logic [1:0] {
    EXEC_NORMAL = 2'b00,
    EXEC_FLUSH  = 2'b01,
    EXEC_FLUSH2 = 2'b10
  } execState_t;
endpackage

// file: src/xor_flag_unit.sv
/*
  exclusive-or with negative and zero flag generation.
  assumes purely combinational use by the decoder.
*/
`timescale 1ns/1ns
module xor_flag_unit
(
  input  wire logic [7:0] opA,
  input  wire logic [7:0] opB,
  output logic      [7:0] result,
  output logic            negFlag,
  output logic            zeroFlag
);
  // result and the two flags it drives
  always_comb
  begin
    result   = opA ^ opB;
    negFlag  = result[7];
    zeroFlag = (result == 8'h00);
  end
endmodule // xor_flag_unit

// file: src/test_skip_xor_ext_decode.sv
/*
  decode and execute of test-and-skip, xor-literal, xor-with-file and the
  extended pointer instructions, including access-bank and indexed address
  selection. assumes one instruction word presented per cycle with a valid
  strobe, and a file-register read port answering in the same cycle.
*/
`timescale 1ns/1ns
`include "xskip_map.svh"
module test_skip_xor_ext_decode
#(
  parameter int PTR_W = 12
)
(
  input  wire logic             sys_clk,
  input  wire logic             arst_n,
  input  wire logic             instrValid,
  input  wire logic [15:0]      instrWord,
  input  wire logic             extended_set_enable_bit,
  input  wire logic [3:0]       bank_select_register,
  input  wire logic [7:0]       fileRdData,
  output logic      [11:0]      fileAddr,
  output logic      [7:0]       fileWrData,
  output logic                  fileWrEn,
  output logic      [7:0]       workReg,
  output logic                  negFlag,
  output logic                  zeroFlag,
  output logic                  squashed,
  output logic                  returnReq,
  output logic                  extDecoded,
  output logic      [PTR_W-1:0] ptr0,
  output logic      [PTR_W-1:0] ptr1,
  output logic      [PTR_W-1:0] third_file_select_pointer
);
  xskip_pkg::execState_t stateReg, stateNext;
  logic [7:0]       workNext;
  logic             negNext, zeroNext;
  logic [11:0]      addrNext;
  logic [7:0]       wrDataNext;
  logic             wrEnNext, squashNext, retNext, extNext;
  logic [PTR_W-1:0] ptrReg  [3];
  logic [PTR_W-1:0] ptrNext [3];
  logic [7:0]       xorRes;
  logic             xorNeg, xorZero;
  logic             isTst, isXorLit, isXorFile, isAddPtr, isSubPtr, isExt;
  logic             isTwoWordFirst, accessBit, destBit, extOn;
  logic [7:0]       fField, xorOperand;
  logic [1:0]       ptrSel, ptrIdx;
  logic [5:0]       ptrLit;

  // opcode field decode
  assign fField    = instrWord[7:0];
  assign accessBit = instrWord[`BIT_ACCESS];
  assign destBit   = instrWord[`BIT_DEST];
  assign extOn     = extended_set_enable_bit;
  assign isTst     = instrWord[15:9] == `OP_TSTSKIP_HI;
  assign isXorLit  = instrWord[15:8] == `OP_XORLIT_HI;
  assign isXorFile = instrWord[15:10] == `OP_XORFILE_HI;
  assign isAddPtr  = extOn && instrWord[15:8] == `OP_ADDPTR_HI;
  assign isSubPtr  = extOn && instrWord[15:8] == `OP_SUBPTR_HI;
  assign isExt     = extOn && (instrWord[15:10] == `OP_EXT_HI
                     || instrWord == `OP_CALL_VIA_WORK);
  // first words of the two-word forms, whose tail is squashed with them when they are skipped
  assign isTwoWordFirst = instrWord[15:12] == `OP_MOVE_PAIR_HI
                     || instrWord[15:9] == `OP_CALL_PAIR_HI
                     || (extOn && instrWord[15:8] == `OP_EXT_PAIR_HI);
  assign ptrSel    = instrWord[7:6];
  assign ptrLit    = instrWord[5:0];
  // selector three aliases pointer two in its returning form
  assign ptrIdx    = (ptrSel == `PTR2_SEL) ? `PTR2_INDEX : ptrSel;
  assign xorOperand = isXorLit ? instrWord[7:0] : fileRdData;

  xor_flag_unit u_xor
  (
    .opA      (workReg),
    .opB      (xorOperand),
    .result   (xorRes),
    .negFlag  (xorNeg),
    .zeroFlag (xorZero)
  );

  // execute: next values for state, work register, flags and pointers
  always_comb
  begin
    stateNext  = stateReg;
    workNext   = workReg;
    negNext    = negFlag;
    zeroNext   = zeroFlag;
    addrNext   = fileAddr;
    wrDataNext = 8'h00;
    wrEnNext   = 1'b0;
    squashNext = 1'b0;
    retNext    = 1'b0;
    extNext    = 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      ptrNext[i] = ptrReg[i];
    end
    // address for the current byte-oriented operand
    if (!accessBit && extOn && fField <= `IDX_LIMIT)
      addrNext = 12'(third_file_select_pointer) + 12'(fField);
    else if (!accessBit)
      addrNext = (fField < `ACCESS_SPLIT) ? {`PAGE_LOW, fField} : {`PAGE_HIGH, fField};
    else
      addrNext = {bank_select_register, fField};
    if (instrValid)
    begin
      case (stateReg)
        xskip_pkg::EXEC_FLUSH:
        begin
          squashNext = 1'b1;
          stateNext  = isTwoWordFirst ? xskip_pkg::EXEC_FLUSH2
                                      : xskip_pkg::EXEC_NORMAL;
        end
        xskip_pkg::EXEC_FLUSH2:
        begin
          squashNext = 1'b1;
          stateNext  = xskip_pkg::EXEC_NORMAL;
        end
        xskip_pkg::EXEC_NORMAL:
        begin
          if (isTst && fileRdData == 8'h00)
            stateNext = xskip_pkg::EXEC_FLUSH;
          else if (isXorLit)
          begin
            workNext = xorRes;
            negNext  = xorNeg;
            zeroNext = xorZero;
          end
          else if (isXorFile)
          begin
            negNext  = xorNeg;
            zeroNext = xorZero;
            if (destBit)
            begin
              wrEnNext   = 1'b1;
              wrDataNext = xorRes;
            end
            else
              workNext = xorRes;
          end
          else if (isAddPtr || isSubPtr)
          begin
            extNext = 1'b1;
            ptrNext[ptrIdx] = isAddPtr ? ptrReg[ptrIdx] + PTR_W'(ptrLit)
                                       : ptrReg[ptrIdx] - PTR_W'(ptrLit);
            if (ptrSel == `PTR2_SEL)
            begin
              retNext   = 1'b1;
              stateNext = xskip_pkg::EXEC_FLUSH2;
            end
          end
          else if (isExt)
            extNext = 1'b1;
        end
        default:
          stateNext = xskip_pkg::EXEC_NORMAL;
      endcase
    end
  end

  // registers
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stateReg   <= xskip_pkg::EXEC_NORMAL;
      workReg    <= `WORK_RESET;
      negFlag    <= 1'b0;
      zeroFlag   <= 1'b0;
      fileAddr   <= `ADDR_RESET;
      fileWrData <= 8'h00;
      fileWrEn   <= 1'b0;
      squashed   <= 1'b0;
      returnReq  <= 1'b0;
      extDecoded <= 1'b0;
      for (int i = 0; i < 3; i++)
      begin
        ptrReg[i] <= PTR_W'(`PTR_RESET);
      end
    end
    else
    begin
      stateReg   <= stateNext;
      workReg    <= workNext;
      negFlag    <= negNext;
      zeroFlag   <= zeroNext;
      fileAddr   <= addrNext;
      fileWrData <= wrDataNext;
      fileWrEn   <= wrEnNext;
      squashed   <= squashNext;
      returnReq  <= retNext;
      extDecoded <= extNext;
      for (int i = 0; i < 3; i++)
      begin
        ptrReg[i] <= ptrNext[i];
      end
    end
  end

  assign ptr0 = ptrReg[0];
  assign ptr1 = ptrReg[1];
  assign third_file_select_pointer = ptrReg[2];

  // rule checks on the core clock, quiet while reset is low

  // a zero operand squashes the word that follows
  a_skip_flush: assert property (@(posedge sys_clk) disable iff (!arst_n)
    instrValid && stateReg == xskip_pkg::EXEC_NORMAL && isTst && fileRdData == 8'h00
    ##1 instrValid |=> squashed) else $error("skip did not squash next word");

  // a non-zero operand lets the next word run
  a_skip_nonzero: assert property (@(posedge sys_clk) disable iff (!arst_n)
    instrValid && stateReg == xskip_pkg::EXEC_NORMAL && isTst && fileRdData != 8'h00
    |=> stateReg == xskip_pkg::EXEC_NORMAL) else $error("skip taken on non-zero operand");

  // a skipped two-word form costs one more squashed cycle
  a_skip_two_word: assert property (@(posedge sys_clk) disable iff (!arst_n)
    instrValid && stateReg == xskip_pkg::EXEC_FLUSH && isTwoWordFirst
    ##1 instrValid |=> squashed) else $error("second word not squashed");

  // the extra squashed cycle is the last one
  a_flush_exit: assert property (@(posedge sys_clk) disable iff (!arst_n)
    instrValid && stateReg == xskip_pkg::EXEC_FLUSH2
    |=> stateReg == xskip_pkg::EXEC_NORMAL) else $error("squash ran past two words");

  // a squashed word writes no file, decodes no extended op and leaves the working register and zero flag untouched
  a_squash_no_exec: assert property (@(posedge sys_clk) disable iff (!arst_n)
    instrValid && stateReg != xskip_pkg::EXEC_NORMAL
    |=> squashed && !fileWrEn && !extDecoded && $stable(workReg) && $stable(zeroFlag))
    else $error("squashed word was executed");

  // xor literal folds the low byte into the working register
  a_xorlit_work: assert property (@(posedge sys_clk) disable iff (!arst_n)
    instrValid && stateReg == xskip_pkg::EXEC_NORMAL && isXorLit
    |=> workReg == ($past(workReg) ^ $past(fField))) else $error("xor literal wrong");

  // destination bit set writes the file, not the working register
  a_xorfile_dest: assert property (@(posedge sys_clk) disable iff (!arst_n)
    instrValid && stateReg == xskip_pkg::EXEC_NORMAL && isXorFile && destBit
    |=> fileWrEn && workReg == $past(workReg)) else $error("xor file dest wrong");

  // destination bit clear writes the working register only
  a_xorfile_work: assert property (@(posedge sys_clk) disable iff (!arst_n)
    instrValid && stateReg == xskip_pkg::EXEC_NORMAL && isXorFile && !destBit
    |=> !fileWrEn && workReg == ($past(workReg) ^ $past(fileRdData))) else $error("xor to w wrong");

  // zero flag follows the stored result
  a_xor_zero_flag: assert property (@(posedge sys_clk) disable iff (!arst_n)
    instrValid && stateReg == xskip_pkg::EXEC_NORMAL && (isXorLit || isXorFile)
    |=> zeroFlag == ((fileWrEn ? fileWrData : workReg) == 8'h00)) else $error("zero flag wrong");

  // negative flag follows bit seven of the stored result
  a_xor_neg_flag: assert property (@(posedge sys_clk) disable iff (!arst_n)
    instrValid && stateReg == xskip_pkg::EXEC_NORMAL && (isXorLit || isXorFile)
    |=> negFlag == (fileWrEn ? fileWrData[7] : workReg[7])) else $error("negative flag wrong");

  // test-and-skip leaves both flags as they were
  a_tst_flags: assert property (@(posedge sys_clk) disable iff (!arst_n)
    instrValid && stateReg == xskip_pkg::EXEC_NORMAL && isTst
    |=> $stable(zeroFlag) && $stable(negFlag)) else $error("skip touched flags");

  // no extended decode or return while the set is off
  a_ext_disabled: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !extended_set_enable_bit
    |=> !extDecoded && !returnReq) else $error("extended op while off");

  // pointers hold still while the set is off
  a_ext_off_ptrs: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !extended_set_enable_bit |=> $stable(ptr0) && $stable(ptr1)
    && $stable(third_file_select_pointer)) else $error("pointer moved while set off");

  // banked operands take their page from the bank select input
  a_bank_select: assert property (@(posedge sys_clk) disable iff (!arst_n)
    accessBit
    |=> fileAddr[11:8] == $past(bank_select_register)) else $error("bank wrong");

  // access-bank operands split at the access boundary
  a_access_page: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !accessBit && !(extOn && fField <= `IDX_LIMIT)
    |=> fileAddr[7:0] == $past(fField) && fileAddr[11:8] == ((fileAddr[7:0] < `ACCESS_SPLIT)
    ? `PAGE_LOW : `PAGE_HIGH)) else $error("access bank address wrong");

  // low operands index off pointer two when extended
  a_indexed_addr: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !accessBit && extOn && fField <= `IDX_LIMIT
    |=> fileAddr == 12'($past(third_file_select_pointer)) + 12'($past(fField)))
    else $error("indexed address wrong");

  // pointer zero moves by the literal in either direction
  a_ptr0_update: assert property (@(posedge sys_clk) disable iff (!arst_n)
    instrValid && stateReg == xskip_pkg::EXEC_NORMAL && (isAddPtr || isSubPtr) && ptrSel == 2'h0
    |=> ptr0 == ($past(isAddPtr) ? $past(ptr0) + PTR_W'($past(ptrLit))
                                 : $past(ptr0) - PTR_W'($past(ptrLit)))) else $error("ptr0 wrong");

  // returning pointer-two forms request a return and squash one cycle
  a_ptr2_return: assert property (@(posedge sys_clk) disable iff (!arst_n)
    instrValid && stateReg == xskip_pkg::EXEC_NORMAL && (isAddPtr || isSubPtr)
    && ptrSel == `PTR2_SEL |=> returnReq && stateReg == xskip_pkg::EXEC_FLUSH2)
    else $error("no return after pointer-two op");

  // main scenarios reached
  c_skip: cover property (@(posedge sys_clk) squashed);
  c_two_word: cover property (@(posedge sys_clk) stateReg == xskip_pkg::EXEC_FLUSH2);
  c_xor_file: cover property (@(posedge sys_clk) fileWrEn);
  c_return: cover property (@(posedge sys_clk) returnReq);
  c_indexed: cover property (@(posedge sys_clk) !accessBit && extOn && fField <= `IDX_LIMIT);
endmodule // test_skip_xor_ext_decode

// file: dv/prog_word_source.sv
/*
  program memory model: hands one fetched word per cycle to the decoder.
  assumes the bench asks for each word on a rising clock edge.
*/
`timescale 1ns/1ns
module prog_word_source
(
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        fetchEn,
  input  wire logic [15:0] fetchWord,
  output logic             instrValid,
  output logic      [15:0] instrWord
);
  logic [15:0] lastWord_reg;

  // remember the last word so an idle bus shows its inverse, not a stale copy
  always_ff @(posedge sys_clk or negedge arst_n)
    if (!arst_n)
      lastWord_reg <= 16'h0000;
    else if (fetchEn)
      lastWord_reg <= fetchWord;

  assign instrValid = fetchEn;
  assign instrWord  = fetchEn ? fetchWord : ~lastWord_reg;
endmodule // prog_word_source

// file: dv/test_skip_xor_ext_decode_test.sv
/*
  self-checking bench for the skip/xor/extended decoder.
  assumes the word source model and the design files are compiled first.
*/
`timescale 1ns/1ns
module test_skip_xor_ext_decode_test;
  logic sys_clk = 1'b0, arst_n = 1'b0, fetchEn = 1'b0, extEn = 1'b0;
  logic [15:0] fetchWord = 16'h0000, instrWord;
  logic [3:0] bank = 4'h5;
  logic [7:0] rdData = 8'h00, fileWrData, workReg;
  logic [11:0] fileAddr, ptr0, ptr1, ptr2;
  logic instrValid, fileWrEn, negFlag, zeroFlag, squashed, returnReq, extDecoded;
  int error_cnt = 0, check_count = 0, cycles = 0;

  prog_word_source src_u (.sys_clk(sys_clk), .arst_n(arst_n), .fetchEn(fetchEn),
    .fetchWord(fetchWord), .instrValid(instrValid), .instrWord(instrWord));

  test_skip_xor_ext_decode #(.PTR_W(12)) dut_u (.sys_clk(sys_clk), .arst_n(arst_n),
    .instrValid(instrValid), .instrWord(instrWord), .extended_set_enable_bit(extEn),
    .bank_select_register(bank), .fileRdData(rdData), .fileAddr(fileAddr),
    .fileWrData(fileWrData), .fileWrEn(fileWrEn), .workReg(workReg), .negFlag(negFlag),
    .zeroFlag(zeroFlag), .squashed(squashed), .returnReq(returnReq),
    .extDecoded(extDecoded), .ptr0(ptr0), .ptr1(ptr1), .third_file_select_pointer(ptr2));

  // clock at 100 MHz
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic summarize();
    if (error_cnt == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // cut a hang short
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      error_cnt++;
      summarize();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    check_count++;
    if (got !== exp)
    begin
      $display("[FAIL] %0t %s got %h want %h", $time, msg, got, exp);
      error_cnt++;
    end
  endtask

  // present one word with its file contents; earlier word's effects show after #1
  task automatic op(input logic [15:0] w, input logic [7:0] rd);
    @(posedge sys_clk);
    fetchEn <= 1'b1;
    fetchWord <= w;
    rdData <= rd;
    #1;
  endtask

  task automatic idle();
    @(posedge sys_clk);
    fetchEn <= 1'b0;
    #1;
  endtask

  task automatic s_xor_literal();
    op(16'h0AB5, 8'h00);
    op(16'h0AAF, 8'h00);
    chk(16'(workReg), 16'h00B5, "xorlit w");
    chk(16'({negFlag, zeroFlag}), 16'h0002, "xorlit nz");
    op(16'h0A1A, 8'h00);
    chk(16'(workReg), 16'h001A, "xorlit w2");
    idle();
    chk(16'({negFlag, zeroFlag}), 16'h0001, "xorlit zero");
  endtask

  task automatic s_xor_file();
    op(16'h0AB5, 8'h00);
    op(16'h1A23, 8'hAF);
    idle();
    chk(16'({fileWrEn, fileWrData}), 16'h011A, "xor_work_with_file to f");
    chk(16'(workReg), 16'h00B5, "xor_work_with_file w kept");
    chk(16'(fileAddr), 16'h0023, "access low");
    op(16'h1980, 8'hB5);
    idle();
    chk(16'({fileWrEn, workReg}), 16'h0000, "xor_work_with_file to w");
    chk(16'({negFlag, zeroFlag}), 16'h0001, "xor_work_with_file nz");
    chk(16'(fileAddr), 16'h0580, "banked");
    op(16'h1880, 8'h00);
    idle();
    chk(16'(fileAddr), 16'h0F80, "access high");
  endtask

  task automatic s_skip();
    op(16'h0A83, 8'h00);
    op(16'h6623, 8'h00);
    op(16'h0A01, 8'h00);
    idle();
    chk(16'({squashed, workReg}), 16'h0183, "skip zero");
    chk(16'({negFlag, zeroFlag}), 16'h0002, "skip flags");
    op(16'h6623, 8'h07);
    op(16'h0A01, 8'h00);
    idle();
    chk(16'({squashed, workReg}), 16'h0082, "no skip");
    op(16'h6623, 8'h00);
    op(16'hC123, 8'h00);
    op(16'hF123, 8'h00);
    op(16'h0A01, 8'h00);
    chk(16'({squashed, workReg}), 16'h0182, "second word dropped");
    idle();
    chk(16'(workReg), 16'h0083, "three cycle skip");
  endtask

  task automatic s_extended();
    op(16'hE8C5, 8'h00);
    idle();
    chk(16'({extDecoded, returnReq, ptr2}), 16'h0000, "ext off");
    @(posedge sys_clk) extEn <= 1'b1;
    op(16'hE803, 8'h00);
    op(16'hE847, 8'h00);
    chk(16'({extDecoded, ptr0}), 16'h1003, "add ptr0");
    op(16'hE8C5, 8'h00);
    chk(16'(ptr1), 16'h0007, "add ptr1");
    op(16'h0A01, 8'h00);
    chk(16'({returnReq, ptr2}), 16'h1005, "add ptr2 ret");
    idle();
    chk(16'({squashed, workReg}), 16'h0183, "ret squash");
    op(16'h0014, 8'h00);
    idle();
    chk(16'({extDecoded, returnReq}), 16'h0002, "call via work decoded");
    op(16'hE9C2, 8'h00);
    idle();
    chk(16'({returnReq, ptr2}), 16'h1003, "sub ptr2 ret");
    op(16'h1823, 8'h00);
    idle();
    chk(16'(fileAddr), 16'h0026, "indexed");
    op(16'h1860, 8'h00);
    idle();
    chk(16'(fileAddr), 16'h0F60, "above index limit");
  endtask

  // reset, then each scenario in turn
  initial
  begin
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    s_xor_literal();
    s_xor_file();
    s_skip();
    s_extended();
    idle();
    summarize();
  end
endmodule // test_skip_xor_ext_decode_test
